// ===== adc_sar_control.sv
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - input at high reference gives ff, at low gives 00, above saturates
// - each conversion takes exactly 32 conversion clocks, clock at least 1 MHz
// - stop mode turns rc oscillator off, power-on bit stays set
// - rc results move into result register on bus clock, one per cycle
// - done flag set when a conversion finishes, result valid
// - done flag cleared by control write or result read
// - after control write, channel converts continuously every 32 cycles
// - each new result overwrites the previous one regardless of flag
// - rc select bit clocks converter from rc oscillator, settle time applies
// - power-on bit enables charge pump and current sources, settle time applies
// - five-bit channel: 00-04 pins, 10 high, 11 mid, 12 low, 13 test
// - in single-chip mode channel 13 converts to zero
// - 8-bit result register updated every time done flag sets
// - input sampled at conversion start, then compared against internal dac
// - wait mode leaves conversion running and done flag untouched
// - stop mode turns off comparator and pump, aborts conversion
// - stop mode leaves result and control registers unchanged
// - five external multiplexed inputs, 8-bit successive-approximation result
module adc_sar_control #(
  parameter int EXT_INPUTS = 5
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                stopMode,
  input  wire logic                waitMode,
  input  wire logic                singleChipMode,
  input  wire logic                rcTick,
  input  wire logic                compHigher,
  output logic      [7:0]          dacCode,
  output logic      [4:0]          muxSelect,
  output logic                     sampleHold,
  output logic                     comparatorOn,
  output logic                     chargePumpOn,
  output logic                     rcOscOn,
  output logic                     resultSettled
);

  initial begin
    if (EXT_INPUTS < 1 || EXT_INPUTS > 5) $error("EXT_INPUTS must be 1..5");
  end

  adc_pkg::adc_state_t s_r;
  adc_pkg::adc_state_t s_nxt;

  logic [1:0] stopSync;
  logic [1:0] rcSync;
  logic [1:0] compSync;
  logic       rcSeen_r;
  logic       stopNow;
  logic       rcEdge;
  logic       compNow;
  logic       convTick;
  logic       wrAccess;
  logic       rdAccess;
  logic       wrCtrl;
  logic       rdResult;
  logic       addrOk;
  logic [7:0] ctrlByte;
  logic [7:0] bitMask;
  logic [7:0] trial;
  logic [7:0] finalCode;
  logic       trialEnd;
  logic [1:0] waitSync;
  logic [1:0] chipSync;
  logic       waitNow;
  logic       chipNow;

  // pin inputs pass two flops
  always_ff @(posedge clk) begin
    if (rst) begin
      stopSync <= 2'b00;
      rcSync   <= 2'b00;
      compSync <= 2'b00;
      waitSync <= 2'b00;
      chipSync <= 2'b00;
      rcSeen_r <= 1'b0;
    end else begin
      waitSync <= {waitSync[0], waitMode};
      chipSync <= {chipSync[0], singleChipMode};
      stopSync <= {stopSync[0], stopMode};
      rcSync   <= {rcSync[0], rcTick};
      compSync <= {compSync[0], compHigher};
      rcSeen_r <= rcSync[1];
    end
  end

  assign stopNow = stopSync[1];
  assign compNow = compSync[1];
  assign waitNow = waitSync[1];
  assign chipNow = chipSync[1];
  assign rcEdge  = rcSync[1] & ~rcSeen_r;

  assign wrAccess = psel & penable & pwrite;
  assign rdAccess = psel & penable & ~pwrite;
  assign addrOk   = (paddr == adc_pkg::ADDR_CTRL) || (paddr == adc_pkg::ADDR_RESULT)
                 || (paddr == adc_pkg::ADDR_MODE) || (paddr == adc_pkg::ADDR_COMP);
  assign wrCtrl   = wrAccess && (paddr == adc_pkg::ADDR_CTRL);
  assign rdResult = rdAccess && (paddr == adc_pkg::ADDR_RESULT);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addrOk;
  assign prdata   = s_r.prdata;

  assign ctrlByte = {s_r.conversionDoneFlag, s_r.ctrl.rcClockSelect,
                     s_r.ctrl.converterPowerOn, s_r.ctrl.channelSelectField};

  assign convTick = s_r.convRc ? rcEdge : 1'b1;

  always_comb begin
    bitMask  = 8'h00;
    trialEnd = 1'b0;
    // each trial held until the synchronised comparator answers
    for (int i = 0; i < adc_pkg::RESULT_BITS; i++) begin
      if (s_r.convCnt >= 5'(adc_pkg::TRIAL_CLOCKS * i + 1)
          && s_r.convCnt <= 5'(adc_pkg::TRIAL_CLOCKS * (i + 1))) bitMask = 8'(8'h80 >> i);
      if (s_r.convCnt == 5'(adc_pkg::TRIAL_CLOCKS * (i + 1))) trialEnd = 1'b1;
    end
    trial = s_r.sarCode | bitMask;
  end

  always_comb begin
    case (s_r.convChannel)
      adc_pkg::CH_REF_HIGH: finalCode = adc_pkg::CODE_FULL;
      adc_pkg::CH_REF_MID:  finalCode = adc_pkg::CODE_MID;
      adc_pkg::CH_REF_LOW:  finalCode = adc_pkg::CODE_ZERO;
      adc_pkg::CH_TEST:     finalCode = chipNow ? adc_pkg::CODE_ZERO : s_r.sarCode;
      default: begin
        if (s_r.convChannel <= adc_pkg::CH_EXT_LAST && 32'(s_r.convChannel) < EXT_INPUTS)
          finalCode = s_r.sarCode;
        else
          finalCode = adc_pkg::CODE_ZERO;
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    // rc result handed over on bus clock
    s_nxt.rcResultValid = 1'b0;
    if (s_r.settleCnt != 10'h000) s_nxt.settleCnt = s_r.settleCnt - 10'h001;
    if (s_r.running && !stopNow && s_r.ctrl.converterPowerOn && convTick) begin
      if (s_r.convCnt == 5'h00) begin
        s_nxt.sarCode    = adc_pkg::CODE_ZERO;
      end else if (trialEnd) begin
        s_nxt.sarCode = compNow ? trial : s_r.sarCode;
      end
      if (s_r.convCnt == 5'(adc_pkg::CONV_CLOCKS - 1)) begin
        s_nxt.convCnt = 5'h00;
        s_nxt.rcPending = s_r.convRc;
        s_nxt.sampleCode = finalCode;
      end else begin
        s_nxt.convCnt = s_r.convCnt + 5'h01;
      end
    end
    if (stopNow) begin
      s_nxt.convCnt = 5'h00;
      s_nxt.rcPending = 1'b0;
    end
    if (s_r.running && !stopNow && s_r.ctrl.converterPowerOn && convTick
        && s_r.convCnt == 5'(adc_pkg::CONV_CLOCKS - 1)) begin
      s_nxt.result = finalCode;
    end
    if (rdResult) s_nxt.conversionDoneFlag = 1'b0;
    if (s_nxt.result != s_r.result || (s_r.running && !stopNow && s_r.ctrl.converterPowerOn
        && convTick && s_r.convCnt == 5'(adc_pkg::CONV_CLOCKS - 1)))
      s_nxt.conversionDoneFlag = 1'b1;
    if (wrCtrl) begin
      // control write clears flag and restarts
      s_nxt.conversionDoneFlag = 1'b0;
      s_nxt.ctrl.rcClockSelect = pwdata[adc_pkg::BIT_RC];
      s_nxt.ctrl.converterPowerOn = pwdata[adc_pkg::BIT_PWR];
      s_nxt.ctrl.channelSelectField = pwdata[4:0];
      s_nxt.running = 1'b1;
      s_nxt.convCnt = 5'h00;
      // source and channel latched at start
      s_nxt.convChannel = pwdata[4:0];
      s_nxt.convRc = pwdata[adc_pkg::BIT_RC];
      // settle timer when power or rc bit goes from clear to set
      if (pwdata[adc_pkg::BIT_PWR] && !s_r.ctrl.converterPowerOn)
        s_nxt.settleCnt = 10'(adc_pkg::PWR_SETTLE_CYC);
      if (pwdata[adc_pkg::BIT_RC] && !s_r.ctrl.rcClockSelect)
        s_nxt.settleCnt = 10'(adc_pkg::RC_SETTLE_CYC);
    end
    // wait mode needs no special handling
    // read data loaded in setup so it stands through the access phase
    if (psel && !penable && !pwrite) begin
      case (paddr)
        adc_pkg::ADDR_CTRL:   s_nxt.prdata = {24'h000000, ctrlByte};
        adc_pkg::ADDR_RESULT: s_nxt.prdata = {24'h000000, s_r.result};
        adc_pkg::ADDR_MODE:   s_nxt.prdata = {29'h0, waitNow, stopNow, chipNow};
        adc_pkg::ADDR_COMP:   s_nxt.prdata = {24'h000000, s_r.sampleCode};
        default:              s_nxt.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dacCode       = s_r.sarCode | bitMask;
  assign muxSelect     = s_r.convChannel;
  assign sampleHold    = s_r.running && (s_r.convCnt == 5'h00);
  assign comparatorOn  = s_r.ctrl.converterPowerOn & ~stopNow;
  assign chargePumpOn  = s_r.ctrl.converterPowerOn & ~stopNow;
  assign rcOscOn       = s_r.ctrl.rcClockSelect & ~stopNow;
  assign resultSettled = (s_r.settleCnt == 10'h000);

endmodule : adc_sar_control

// ===== adc_pkg.sv
package adc_pkg;
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_RESULT  = 12'h004;
  localparam logic [11:0] ADDR_MODE    = 12'h008;
  localparam logic [11:0] ADDR_COMP    = 12'h00c;
  localparam int          CONV_CLOCKS  = 32;
  localparam int          RESULT_BITS  = 8;
  localparam int          TRIAL_CLOCKS = 3;
  localparam logic [7:0]  CODE_FULL    = 8'hff;
  localparam logic [7:0]  CODE_ZERO    = 8'h00;
  localparam logic [7:0]  CODE_MID     = 8'h80;
  localparam logic [4:0]  CH_EXT_LAST  = 5'h04;
  localparam logic [4:0]  CH_REF_HIGH  = 5'h10;
  localparam logic [4:0]  CH_REF_MID   = 5'h11;
  localparam logic [4:0]  CH_REF_LOW   = 5'h12;
  localparam logic [4:0]  CH_TEST      = 5'h13;
  localparam int          BIT_DONE     = 7;
  localparam int          BIT_RC       = 6;
  localparam int          BIT_PWR      = 5;
  localparam int          RC_SETTLE_NS  = 1000;
  localparam int          PWR_SETTLE_NS = 1000;
  localparam int          CLK_NS        = 10;
  localparam int          RC_SETTLE_CYC  = (RC_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int          PWR_SETTLE_CYC = (PWR_SETTLE_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic       rcClockSelect;
    logic       converterPowerOn;
    logic [4:0] channelSelectField;
  } adc_ctrl_t;

  typedef struct packed {
    adc_ctrl_t  ctrl;
    logic       conversionDoneFlag;
    logic [7:0] result;
    logic       running;
    logic [4:0] convCnt;
    logic [7:0] sarCode;
    logic [7:0] sampleCode;
    logic [4:0] convChannel;
    logic       convRc;
    logic       rcPending;
    logic       rcResultValid;
    logic [7:0] rcResult;
    logic [9:0] settleCnt;
    logic [31:0] prdata;
  } adc_state_t;
endpackage : adc_pkg

// ===== adc_sar_control_props.sv
`timescale 1ns/1ps
module adc_sar_control_props #(parameter int EXT_INPUTS = 5) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        stopMode,
  input wire logic        sampleHold,
  input wire logic        comparatorOn,
  input wire logic        chargePumpOn,
  input wire logic        rcOscOn
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic       acc, wr, rd, map, odd_r;
  logic [6:0] ctl_r;
  logic [5:0] gap_r, age_r;
  assign acc = psel && penable;
  assign wr  = acc && pwrite && paddr == adc_pkg::ADDR_CTRL;
  assign rd  = acc && !pwrite && paddr == adc_pkg::ADDR_CTRL;
  assign map = paddr[11:4] == 8'h00 && paddr[1:0] == 2'h0;
  // odd_r marks a period broken by a write, stop or rc clocking
  always_ff @(posedge clk) begin
    ctl_r <= rst ? 7'h00 : wr ? pwdata[6:0] : ctl_r;
    age_r <= rst ? 6'h3f : wr ? 6'h00 : age_r + {5'h00, age_r != 6'h3f};
    odd_r <= rst || wr || stopMode || ctl_r[6] || (odd_r && !sampleHold);
    gap_r <= sampleHold ? 6'h00 : gap_r + {5'h00, gap_r != 6'h3f};
  end
  sequence stop_held;
    stopMode [*4];
  endsequence
  slverr_a: assert property (acc |-> pslverr == !map) else $error("slverr wrong");
  ctl_keep_a: assert property (rd |-> prdata[6:0] == ctl_r) else $error("control lost");
  flag_clr_a: assert property (rd && age_r < 6'h1e |-> !prdata[7]) else $error("flag kept");
  period_a: assert property ($rose(sampleHold) && !odd_r |-> gap_r == 6'h1f) else $error("bad period");
  rc_stop_a: assert property (stop_held |-> !rcOscOn) else $error("rc on");
  cmp_stop_a: assert property (stop_held |-> !comparatorOn) else $error("comparator on");
  pump_stop_a: assert property (stop_held |-> !chargePumpOn) else $error("pump on");
  pump_off_a: assert property (wr && !pwdata[5] |-> ##[1:4] !chargePumpOn) else $error("pump kept");
endmodule : adc_sar_control_props

// ===== adc_analog_model.sv
`timescale 1ns/1ps
module adc_analog_model (
  input  wire logic [7:0]  dacCode,
  input  wire logic [4:0]  muxSelect,
  input  wire logic        rcOscOn,
  input  wire logic [39:0] extLevel,
  output logic             compHigher,
  output logic             rcTick = 1'b0
);
  logic [7:0] lvl;
  assign lvl = muxSelect < 5'h05 ? extLevel[8*muxSelect+:8] : muxSelect == 5'h10 ? 8'hff
    : muxSelect == 5'h11 ? adc_pkg::CODE_MID : muxSelect == 5'h13 ? 8'ha5 : 8'h00;
  assign compHigher = lvl >= dacCode;
  // free rc clock, halted while off
  always #333 rcTick = rcOscOn ? ~rcTick : rcTick;
endmodule : adc_analog_model

// ===== tb_adc_sar_control.sv
`timescale 1ns/1ps
module tb_adc_sar_control;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic        stopMode = 1'b0, waitMode = 1'b0, singleChipMode = 1'b0, pready, pslverr, rcTick;
  logic        compHigher, sampleHold, comparatorOn, chargePumpOn, rcOscOn, resultSettled;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [39:0] extLevel = 40'h0;
  logic [7:0]  dacCode;
  logic [4:0]  muxSelect;
  int          miscompares = 0, checks_done = 0;
  always #5 clk = ~clk;
  adc_sar_control i_dut (.*);
  adc_analog_model i_model (.*);
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(posedge clk);
  endtask : bus
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    miscompares += int'(seen !== exp);
    if (seen !== exp) $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
  endtask : check
  task automatic end_sim;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  function automatic logic [7:0] code(input logic [4:0] c);
    return c == 5'h10 ? 8'hff : c == 5'h11 ? adc_pkg::CODE_MID : c > 5'h04 ? 8'h00 : extLevel[8*c+:8];
  endfunction : code
  task automatic conv(input logic [6:0] c);
    bus(1'b1, adc_pkg::ADDR_CTRL, {25'h0, c});
    rd = 32'h0;
    while (rd[7] !== 1'b1) bus(1'b0, adc_pkg::ADDR_CTRL, 32'h0);
    bus(1'b0, adc_pkg::ADDR_RESULT, 32'h0);
    check(rd, {24'h0, code(c[4:0])});
    bus(1'b0, adc_pkg::ADDR_CTRL, 32'h0);
    check(rd, {25'h0, c});
  endtask : conv
  initial begin
    void'($urandom(32'h0cd5a0f1));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, adc_pkg::ADDR_RESULT, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 12'h010, 32'h0);
    check({31'h0, err}, 32'h1);
    $display("reset test done");
    for (int i = 0; i < 9; i++) begin
      {extLevel, singleChipMode, waitMode} <= {8'hff, $urandom, i == 8, i[0]};
      conv(7'(i < 5 ? 32 + i : 43 + i));
      if (i == 0) check({31'h0, resultSettled}, 32'h0);
    end
    $display("channel test done");
    conv(7'h20);
    extLevel <= ~extLevel;
    repeat (100) @(posedge clk);
    bus(1'b0, adc_pkg::ADDR_RESULT, 32'h0);
    check(rd, {24'h0, code(5'h00)});
    conv(7'h61);
    stopMode <= 1'b1;
    repeat (6) @(posedge clk);
    check({29'h0, comparatorOn, chargePumpOn, rcOscOn}, 32'h0);
    bus(1'b0, adc_pkg::ADDR_CTRL, 32'h0);
    check(rd, 32'h61);
    stopMode <= 1'b0;
    bus(1'b1, adc_pkg::ADDR_CTRL, 32'h0);
    repeat (6) @(posedge clk);
    check({31'h0, resultSettled}, 32'h1);
    $display("mode test done");
    end_sim();
  end
  initial begin
    #500us;
    miscompares++;
    end_sim();
  end
endmodule : tb_adc_sar_control
bind adc_sar_control adc_sar_control_props #(.EXT_INPUTS(EXT_INPUTS)) i_props (.*);
